// >>> wdf_pkg.sv
// constants shared by the watchdog overflow flag block
// How it works
// - flag sits in bit 7 of the control/status register, 0 after reset.
// - flag sets when the 8-bit counter wraps ff to 00 in interval mode.
// - by software, flag clears only after reading it as 1 and then writing 0 to it.
// - on the watch-timer channel, writing 0 to enable also clears it.
// - internal reset raised in watchdog reset mode clears the flag.
// - flag never sets while the counter runs in watchdog mode.
package wdf_pkg;

    // ****************************************
    // register layout
    // ****************************************
    localparam int unsigned  REG_W      = 8;
    localparam int unsigned  FLAG_BIT   = 7;
    localparam int unsigned  MODE_BIT   = 6;
    localparam int unsigned  ENABLE_BIT = 5;
    localparam int unsigned  RSEL_BIT   = 4;
    localparam int unsigned  CKS_LSB    = 0;
    localparam int unsigned  CKS_W      = 3;
    localparam logic [7:0]   CSR_RESET  = 8'h00;
    localparam logic [7:0]   CSR_WMASK  = 8'h77;

    // ****************************************
    // counter
    // ****************************************
    localparam int unsigned  CNT_W      = 8;
    localparam logic [7:0]   CNT_MAX    = 8'hff;
    localparam logic [7:0]   CNT_ZERO   = 8'h00;

    // ****************************************
    // prescaler taps
    // ****************************************
    localparam int unsigned  PRE_W      = 13;

    typedef logic [PRE_W-1:0] wdf_pre_t;

    // tick when all counter bits under the mask are ones: divide by mask + 1
    function automatic wdf_pre_t wdf_tap_mask(input logic [2:0] cks);
        wdf_pre_t m;
        m = 13'h0000;
        case (cks)
            3'h0: m = 13'h0001;
            3'h1: m = 13'h001f;
            3'h2: m = 13'h003f;
            3'h3: m = 13'h007f;
            3'h4: m = 13'h00ff;
            3'h5: m = 13'h01ff;
            3'h6: m = 13'h07ff;
            default: m = 13'h0fff;
        endcase
        return m;
    endfunction

    typedef enum logic [1:0] {
        WDF_IDLE  = 2'b01,
        WDF_ARMED = 2'b10
    } wdf_clr_t;

endpackage

// >>> wdf_prescaler.sv
// free-running prescaler that pulses at the selected division
`timescale 1ns/100ps
module wdf_prescaler #(
    parameter int unsigned W = 13
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_run,
    input  wire logic [W-1:0] i_mask,
    output logic              o_tick
);
    logic [W-1:0] cnt_r;
    wire  logic   hit = ((cnt_r & i_mask) == i_mask);

    // prescaler restarts when the timer stops so the first tick is a full period
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_run) begin
            cnt_r  <= '0;
            o_tick <= 1'b0;
        end else begin
            cnt_r  <= cnt_r + 1'b1;
            o_tick <= hit;
        end
    end
endmodule

// >>> wdf_timer.sv
// watchdog / interval timer with its overflow status flag
`timescale 1ns/100ps
module wdf_timer #(
    parameter bit IS_WATCH_CHANNEL = 1'b0
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_csr_rd,
    input  wire logic                  i_csr_wr,
    input  wire logic [wdf_pkg::REG_W-1:0] i_csr_wdata,
    input  wire logic                  i_cnt_wr,
    input  wire logic [wdf_pkg::CNT_W-1:0] i_cnt_wdata,
    input  wire logic                  i_irq_en,
    output logic [wdf_pkg::REG_W-1:0]  o_csr_rdata,
    output logic [wdf_pkg::CNT_W-1:0]  o_count,
    output logic                       o_overflow_flag,
    output logic                       o_irq,
    output logic                       o_int_rst
);
    import wdf_pkg::*;

    // ****************************************
    // state
    // ****************************************
    logic [REG_W-1:0] csr_r;
    logic [REG_W-1:0] csr_nxt;
    logic [CNT_W-1:0] up_counter_r;
    logic [CNT_W-1:0] up_counter_nxt;
    logic             overflow_flag_r;
    logic             overflow_flag_nxt;
    wdf_clr_t         clr_r;
    wdf_clr_t         clr_nxt;
    logic             tick;

    // ****************************************
    // decode
    // ****************************************
    wire logic timer_enable_bit = csr_r[ENABLE_BIT];
    wire logic wd_mode          = csr_r[MODE_BIT];
    wire logic rst_sel          = csr_r[RSEL_BIT];
    wire logic [CKS_W-1:0] cks  = csr_r[CKS_LSB +: CKS_W];
    // a counter write overrides the tick, so it never counts as a wrap
    wire logic wrap             = timer_enable_bit && tick && !i_cnt_wr
                                  && (up_counter_r == CNT_MAX);

    wire logic flag_set  = wrap && !wd_mode;
    // watchdog in reset mode: overflow requests the internal reset
    wire logic rst_req   = wrap && wd_mode && rst_sel;
    // internal reset pulse clears flag and counter one cycle later
    wire logic int_clear = o_int_rst;

    // read of a set flag arms the clear
    wire logic arm       = i_csr_rd && overflow_flag_r;
    wire logic wr_flag0  = i_csr_wr && !i_csr_wdata[FLAG_BIT];
    wire logic sw_clear  = wr_flag0 && (clr_r == WDF_ARMED);
    wire logic enable_clear = IS_WATCH_CHANNEL && i_csr_wr
                              && !i_csr_wdata[ENABLE_BIT];

    // ****************************************
    // prescaler
    // ****************************************
    wdf_prescaler #(
        .W      (PRE_W)
    ) u_pre (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_run  (timer_enable_bit),
        .i_mask (wdf_tap_mask(cks)),
        .o_tick (tick)
    );

    // ****************************************
    // next-state
    // ****************************************
    always_comb begin
        csr_nxt = csr_r;
        if (i_csr_wr) begin
            csr_nxt = i_csr_wdata & CSR_WMASK;
        end
    end

    // an overflow in the same cycle as a clear wins
    always_comb begin
        overflow_flag_nxt = overflow_flag_r;
        if (sw_clear || enable_clear || int_clear) begin
            overflow_flag_nxt = 1'b0;
        end
        if (flag_set) begin
            overflow_flag_nxt = 1'b1;
        end
    end

    // arm survives reads; any write consumes it, so a stale arm cannot
    // clear a later overflow
    always_comb begin
        clr_nxt = clr_r;
        case (clr_r)
            WDF_IDLE: begin
                if (arm && !i_csr_wr) begin
                    clr_nxt = WDF_ARMED;
                end
            end
            WDF_ARMED: begin
                if (i_csr_wr) begin
                    clr_nxt = WDF_IDLE;
                end
            end
            default: clr_nxt = WDF_IDLE;
        endcase
        if (int_clear) begin
            clr_nxt = WDF_IDLE;
        end
    end

    // stopped timer holds zero
    always_comb begin
        up_counter_nxt = up_counter_r;
        if (!timer_enable_bit || int_clear) begin
            up_counter_nxt = CNT_ZERO;
        end else if (i_cnt_wr) begin
            up_counter_nxt = i_cnt_wdata;
        end else if (tick) begin
            up_counter_nxt = up_counter_r + 1'b1;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            csr_r           <= CSR_RESET;
            overflow_flag_r <= 1'b0;
            clr_r           <= WDF_IDLE;
            up_counter_r    <= CNT_ZERO;
        end else begin
            csr_r           <= csr_nxt;
            overflow_flag_r <= overflow_flag_nxt;
            clr_r           <= clr_nxt;
            up_counter_r    <= up_counter_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_csr_rdata     <= CSR_RESET;
            o_count         <= CNT_ZERO;
            o_overflow_flag <= 1'b0;
            o_irq           <= 1'b0;
            o_int_rst       <= 1'b0;
        end else begin
            o_csr_rdata     <= csr_nxt;
            // flag shown in bit 7
            o_csr_rdata[FLAG_BIT] <= overflow_flag_nxt;
            o_count         <= up_counter_nxt;
            o_overflow_flag <= overflow_flag_nxt;
            o_irq           <= overflow_flag_nxt && i_irq_en;
            o_int_rst       <= rst_req;
        end
    end
endmodule

// >>> wdf_chk_assertions.sv
// checker for the watchdog overflow flag block
`timescale 1ns/100ps
module wdf_chk #(
    parameter bit IS_WATCH_CHANNEL = 1'b0
) (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_csr_rd,
    input wire logic       i_csr_wr,
    input wire logic [7:0] i_csr_wdata,
    input wire logic       i_cnt_wr,
    input wire logic [7:0] i_cnt_wdata,
    input wire logic       i_irq_en,
    input wire logic [7:0] o_csr_rdata,
    input wire logic [7:0] o_count,
    input wire logic       o_overflow_flag,
    input wire logic       o_irq,
    input wire logic       o_int_rst
);
    logic armed_r;
    // shadow of the read-of-1 arming; any write drops it, so a late
    // write of 0 cannot pass as a legal clear
    always_ff @(posedge i_clk) begin
        if (i_rst || i_csr_wr) begin
            armed_r <= 1'b0;
        end else if (i_csr_rd && o_overflow_flag) begin
            armed_r <= 1'b1;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    bit7_flag_a: assert property (
        o_overflow_flag == o_csr_rdata[7]) else $error("flag not in bit 7");
    rst_clear_a: assert property (disable iff (1'b0)
        i_rst |=> o_csr_rdata == 8'h00) else $error("register not 00");
    wrap_set_a: assert property ($rose(o_overflow_flag) |->
        o_count == 8'h00 && !$past(o_csr_rdata[6]))
        else $error("flag set off wrap");
    wd_no_set_a: assert property (o_csr_rdata[6] |=>
        !$rose(o_overflow_flag)) else $error("flag set in watchdog mode");
    read_first_a: assert property ($fell(o_overflow_flag)
        && !$past(o_int_rst) && !(IS_WATCH_CHANNEL && $past(i_csr_wr)
        && !$past(i_csr_wdata[5])) |-> $past(i_csr_wr) && $past(armed_r))
        else $error("flag cleared without read of 1");
    watch_clr_a: assert property (IS_WATCH_CHANNEL && i_csr_wr
        && !i_csr_wdata[5] && o_count != 8'hff |=> !o_overflow_flag)
        else $error("enable off kept flag");
    int_rst_clr_a: assert property (o_int_rst |->
        $past(o_count) == 8'hff ##1 !o_overflow_flag)
        else $error("internal reset wrong");
    irq_tie_a: assert property (o_irq ==
        (o_overflow_flag && $past(i_irq_en))) else $error("irq wrong");
    cover property ($rose(o_overflow_flag));
    cover property ($fell(o_overflow_flag) && $past(armed_r));
    cover property (o_int_rst);
    cover property (IS_WATCH_CHANNEL && i_csr_wr && !i_csr_wdata[5]
        && o_overflow_flag);
endmodule

// >>> tb_watchdog_overflow_flag.sv
// testbench for the watchdog overflow flag block
`timescale 1ns/100ps
bind wdf_timer wdf_chk #(.IS_WATCH_CHANNEL(IS_WATCH_CHANNEL)) u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_csr_rd(i_csr_rd), .i_csr_wr(i_csr_wr),
    .i_csr_wdata(i_csr_wdata), .i_cnt_wr(i_cnt_wr), .i_irq_en(i_irq_en),
    .i_cnt_wdata(i_cnt_wdata), .o_csr_rdata(o_csr_rdata), .o_irq(o_irq),
    .o_count(o_count), .o_overflow_flag(o_overflow_flag),
    .o_int_rst(o_int_rst));
module tb_watchdog_overflow_flag;
    import wdf_pkg::*;
    typedef struct {logic rd; logic [7:0] wd; logic [7:0] ex;
                    logic [7:0] ex0;} wdf_row_t;
    logic       i_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic       rd = 1'b0;
    logic       wr = 1'b0;
    logic       cw = 1'b0;
    logic       ie = 1'b1;
    logic [7:0] wd = 8'h00;
    logic [7:0] rdata;
    logic [7:0] cnt;
    logic       flag;
    logic       flag0;
    logic       irq;
    logic       irst;
    int         failures = 0;
    int         tests_run = 0;
    // write of 0 unarmed, enable off, write of 1 armed, armed clear;
    // ex0 is the other channel kind, where enable off leaves the flag
    wdf_row_t   rows [4] = '{'{1'b0, 8'h20, 8'h01, 8'h01},
                             '{1'b0, 8'h00, 8'h00, 8'h01},
                             '{1'b1, 8'ha0, 8'h01, 8'h01},
                             '{1'b1, 8'h20, 8'h00, 8'h00}};
    wdf_timer #(.IS_WATCH_CHANNEL(1'b1)) uut (
        .i_clk(i_clk), .i_rst(i_rst), .i_csr_rd(rd), .i_csr_wr(wr),
        .i_csr_wdata(wd), .i_cnt_wr(cw), .i_cnt_wdata(8'hff),
        .i_irq_en(ie), .o_csr_rdata(rdata), .o_count(cnt),
        .o_overflow_flag(flag), .o_irq(irq), .o_int_rst(irst));
    // same stimulus into the non-watch channel kind
    wdf_timer #(.IS_WATCH_CHANNEL(1'b0)) uut_ch0 (
        .i_clk(i_clk), .i_rst(i_rst), .i_csr_rd(rd), .i_csr_wr(wr),
        .i_csr_wdata(wd), .i_cnt_wr(cw), .i_cnt_wdata(8'hff),
        .i_irq_en(ie), .o_csr_rdata(), .o_count(),
        .o_overflow_flag(flag0), .o_irq(), .o_int_rst());
    always #25 i_clk = ~i_clk;
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #5;
    endtask
    // an idle edge after every strobe, so two calls in a row never
    // lower and raise one strobe in the same time step
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(1);
    endtask
    // counter loaded with ff so a wrap comes within a few prescaler ticks
    task automatic run_ff(input logic [7:0] m);
        wd = m;
        pulse(wr);
        pulse(cw);
        for (int k = 0; k < 20 && cnt !== 8'h00; k++) begin
            step(1);
        end
        // a wrap that never comes counts as a mismatch here
        cmp("counter wrap", 8'h00, cnt);
    endtask
    task automatic cmp(input string nm, input logic [7:0] ex, got);
        tests_run++;
        if (got !== ex) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // the run needs under a hundred cycles; 3000 cycles is the limit
    initial begin
        #(3000 * 50);
        failures++;
        end_of_test();
    end
    initial begin
        step(8);
        i_rst = 1'b0;
        cmp("reset csr", 8'h00, rdata);
        $display("reset test done");
        foreach (rows[i]) begin
            run_ff(8'h20);
            cmp("flag bit", 8'h80, rdata & 8'h80);
            if (rows[i].rd) begin
                pulse(rd); // polling software reads 1 twice
                pulse(rd);
            end
            wd = rows[i].wd;
            pulse(wr);
            cmp("flag", rows[i].ex, {7'h00, flag});
            cmp("flag ch0", rows[i].ex0, {7'h00, flag0});
            cmp("irq", rows[i].ex, {7'h00, irq});
            $display("row %0d done", i);
        end
        ie = 1'b0;
        run_ff(8'h20);
        cmp("irq masked", 8'h00, {7'h00, irq});
        ie = 1'b1;
        step(1);
        cmp("irq", 8'h01, {7'h00, irq});
        pulse(rd);
        run_ff(8'h60);
        cmp("watchdog flag", 8'h00, rdata & 8'h80);
        run_ff(8'h20);
        cmp("flag set", 8'h01, {7'h00, flag});
        run_ff(8'h70);
        cmp("int rst", 8'h01, {7'h00, irst});
        step(1);
        cmp("flag", 8'h00, {7'h00, flag});
        $display("mode tests done");
        // reset in mid-run while the flag is set
        run_ff(8'h20);
        cmp("flag before reset", 8'h01, {7'h00, flag});
        i_rst = 1'b1;
        step(2);
        i_rst = 1'b0;
        cmp("reset flag", 8'h00, {7'h00, flag});
        cmp("reset flag ch0", 8'h00, {7'h00, flag0});
        cmp("reset csr again", 8'h00, rdata);
        $display("mid-run reset test done");
        end_of_test();
    end
endmodule
